// >>> logic/prs_pc_stack.sv
// program counter, return address stack and fast shadow registers
//
// Notes on behaviour
// - program counter is 21 bits held as low, high and upper bytes.
// - only the low byte is software visible; high and upper go via latches. The code also reads the whole counter at OFF_PC_VIEW.
// - writing the low byte also loads high and upper from their latches.
// - reading the low byte copies high and upper bytes into the latches.
// - bit 0 is always zero; sequential flow adds two.
// - jumps, calls and branches load the counter directly, ignoring latches.
// - stack is 31 entries of 21 bits with 5-bit pointer, unmapped.
// - calls and interrupt acks push, exits pop; latches untouched.
// - push increments pointer first, then stores the return address.
// - pop loads counter from the top entry, then decrements pointer.
// - reset clears pointer; pointer zero has no entry behind it.
// - three top-of-stack registers read and write the addressed entry.
// - pointer value 0 to 31 is readable and writable.
// - full flag sets after 31 pushes; cleared by software or power-on.
// - fault reset on: 31st push stores pc plus two, sets full, resets.
// - fault reset off: pointer stops at 31, no overwrite of last entry.
// - pop when empty loads zero, sets underflow, pointer stays zero.
// - full or underflow resets the device only when fault reset enabled.
// - pointer register: full bit 7, underflow bit 6, bit 5 zero, level 4-0.
// - push instruction stores counter; discard only drops the top.
// - shadow of status, working, bank loads on interrupt; fast exit restores.
// - fast call saves the three registers, fast return restores them.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module prs_pc_stack (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [prs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core commands
    input wire logic op_valid_i,
    input wire prs_pkg::prs_op_e op_code_i,
    input wire logic [prs_pkg::PC_W-1:0] op_target_i,
    input wire logic [7:0] core_status_i,
    input wire logic [7:0] core_working_i,
    input wire logic [7:0] core_bank_i,
    // core results
    output logic [prs_pkg::PC_W-1:0] pc_o,
    output logic restore_o,
    output logic [7:0] shadow_status_o,
    output logic [7:0] shadow_working_o,
    output logic [7:0] shadow_bank_o,
    output logic fault_reset_o
);
    import prs_pkg::*;

    // ******************************
    // helpers
    // ******************************
    function automatic logic [PC_W-1:0] pc_plus2(input logic [PC_W-1:0] pc);
        pc_plus2 = pc + PC_STEP;
    endfunction

    function automatic logic [PC_W-1:0] word_align(input logic [PC_W-1:0] adr);
        word_align = {adr[PC_W-1:1], 1'b0};
    endfunction

    // ******************************
    // state
    // ******************************
    logic [PC_W-1:0] pc_r;
    logic [7:0] high_latch_r;
    logic [4:0] upper_latch_r;
    logic [SP_W-1:0] sp_r;
    logic full_r, underflow_r, fault_enable_r, fault_reset_r, ack_r;
    logic [31:0] dat_r;
    logic [7:0] sh_status_r, sh_working_r, sh_bank_r;
    logic [PC_W-1:0] stack_mem [1:STACK_DEPTH];

    // ******************************
    // decode
    // ******************************
    logic bus_req, bus_fire, bus_wr, bus_rd;
    logic is_push, is_pop, push_full, push_over, pop_empty, fault;
    logic [SP_W-1:0] sp_inc;
    logic [PC_W-1:0] tos;

    assign bus_req = wb_cyc_i & wb_stb_i;
    // effects land on the edge where the master sees ack
    assign bus_fire = bus_req & ack_r;
    assign bus_wr = bus_fire & wb_we_i & wb_sel_i[0];
    assign bus_rd = bus_fire & ~wb_we_i;

    // push and pop sources
    // push and pop
    assign is_push = op_valid_i & (op_code_i == OP_CALL || op_code_i == OP_CALL_FAST ||
                                   op_code_i == OP_INT_ACK || op_code_i == OP_PUSH);
    assign is_pop = op_valid_i & (op_code_i == OP_RETURN || op_code_i == OP_RETURN_FAST ||
                                  op_code_i == OP_INT_EXIT || op_code_i == OP_INT_EXIT_FAST ||
                                  op_code_i == OP_DISCARD);
    assign push_full = is_push & (sp_r == SP_LAST_FREE);
    assign push_over = is_push & (sp_r == SP_TOP);
    assign pop_empty = is_pop & (sp_r == SP_EMPTY);
    assign fault = fault_enable_r & (push_full | push_over | pop_empty);
    assign sp_inc = sp_r + 5'h01;
    assign tos = (sp_r == SP_EMPTY) ? PC_RESET : stack_mem[sp_r];

    // ******************************
    // wishbone handshake
    // ******************************
    // one wait state: ack rises the cycle after the request, drops after one cycle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dat_r <= 32'h0000_0000;
        end else if (bus_req & ~ack_r) begin
            case (wb_adr_i)
                OFF_PC_LOW: dat_r <= {24'h00_0000, pc_r[7:0]};
                OFF_HIGH_LATCH: dat_r <= {24'h00_0000, high_latch_r};
                OFF_UPPER_LATCH: dat_r <= {27'h000_0000, upper_latch_r};
                OFF_STACK_PTR: dat_r <= {24'h00_0000, full_r, underflow_r, 1'b0, sp_r};
                OFF_TOP_LOW: dat_r <= {24'h00_0000, tos[7:0]};
                OFF_TOP_HIGH: dat_r <= {24'h00_0000, tos[15:8]};
                OFF_TOP_UPPER: dat_r <= {27'h000_0000, tos[20:16]};
                OFF_CONFIG: dat_r <= {31'h0000_0000, fault_enable_r};
                OFF_PC_VIEW: dat_r <= {11'h000, pc_r};
                default: dat_r <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ******************************
    // configuration
    // ******************************
    // fault reset never clears this bit, it stands for a fuse setting
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_enable_r <= FAULT_RESET_DEFAULT;
        end else if (bus_wr && wb_adr_i == OFF_CONFIG) begin
            fault_enable_r <= wb_dat_i[CFG_FAULT_RESET_BIT];
        end
    end

    // ******************************
    // program counter
    // ******************************
    // core commands outrank a bus write of the low byte in the same cycle
    // 21-bit counter
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_r <= PC_RESET;
        end else if (fault) begin
            pc_r <= PC_RESET;
        end else if (op_valid_i) begin
            case (op_code_i)
                OP_STEP, OP_PUSH, OP_DISCARD: pc_r <= pc_plus2(pc_r);
                OP_JUMP, OP_CALL, OP_CALL_FAST, OP_INT_ACK: pc_r <= word_align(op_target_i);
                OP_RETURN, OP_RETURN_FAST, OP_INT_EXIT, OP_INT_EXIT_FAST:
                    pc_r <= pop_empty ? PC_RESET : word_align(tos);
                default: pc_r <= pc_r;
            endcase
        end else if (bus_wr && wb_adr_i == OFF_PC_LOW) begin
            pc_r <= {upper_latch_r, high_latch_r, wb_dat_i[7:1], 1'b0};
        end
    end

    assign pc_o = pc_r;

    // ******************************
    // counter latches
    // ******************************
    // calls and returns leave the latches alone
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_latch_r <= LATCH_RESET;
            upper_latch_r <= LATCH_RESET[4:0];
        end else if (fault) begin
            high_latch_r <= LATCH_RESET;
            upper_latch_r <= LATCH_RESET[4:0];
        end else if (bus_rd && wb_adr_i == OFF_PC_LOW) begin
            high_latch_r <= pc_r[15:8];
            upper_latch_r <= pc_r[20:16];
        end else if (bus_wr && wb_adr_i == OFF_HIGH_LATCH) begin
            high_latch_r <= wb_dat_i[7:0];
        end else if (bus_wr && wb_adr_i == OFF_UPPER_LATCH) begin
            upper_latch_r <= wb_dat_i[4:0];
        end
    end

    // ******************************
    // stack pointer
    // ******************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp_r <= SP_RESET;
        end else if (fault) begin
            sp_r <= SP_RESET;
        end else if (is_push) begin
            sp_r <= push_over ? SP_TOP : sp_inc;
        end else if (is_pop) begin
            sp_r <= pop_empty ? SP_EMPTY : sp_r - 5'h01;
        end else if (bus_wr && wb_adr_i == OFF_STACK_PTR) begin
            sp_r <= wb_dat_i[SP_W-1:0];
        end
    end

    // ******************************
    // status flags
    // ******************************
    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            full_r <= 1'b0;
            underflow_r <= 1'b0;
        end else begin
            if (push_full | push_over) begin
                full_r <= 1'b1;
            end else if (bus_wr && wb_adr_i == OFF_STACK_PTR && !wb_dat_i[SP_FULL_BIT]) begin
                full_r <= 1'b0;
            end
            if (pop_empty) begin
                underflow_r <= 1'b1;
            end else if (bus_wr && wb_adr_i == OFF_STACK_PTR && !wb_dat_i[SP_UNDERFLOW_BIT]) begin
                underflow_r <= 1'b0;
            end
        end
    end

    // ******************************
    // stack storage
    // ******************************
    // unmapped storage array
    always_ff @(posedge clock_i) begin
        if (is_push && !push_over) begin
            // last push stores pc plus two when faulting
            stack_mem[sp_inc] <= fault ? pc_plus2(pc_r) : pc_r;
        end else if (bus_wr && sp_r != SP_EMPTY && !is_pop) begin
            case (wb_adr_i)
                OFF_TOP_LOW: stack_mem[sp_r] <= {tos[20:8], wb_dat_i[7:0]};
                OFF_TOP_HIGH: stack_mem[sp_r] <= {tos[20:16], wb_dat_i[7:0], tos[7:0]};
                OFF_TOP_UPPER: stack_mem[sp_r] <= {wb_dat_i[4:0], tos[15:0]};
                default: stack_mem[sp_r] <= tos;
            endcase
        end
    end

    // ******************************
    // fault reset pulse
    // ******************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_reset_r <= 1'b0;
        end else begin
            fault_reset_r <= fault;
        end
    end

    assign fault_reset_o = fault_reset_r;

    // ******************************
    // fast shadow registers
    // ******************************
    // one level only: a nested interrupt overwrites what the outer one saved
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_status_r <= 8'h00;
            sh_working_r <= 8'h00;
            sh_bank_r <= 8'h00;
        end else if (op_valid_i && (op_code_i == OP_INT_ACK || op_code_i == OP_CALL_FAST)) begin
            sh_status_r <= core_status_i;
            sh_working_r <= core_working_i;
            sh_bank_r <= core_bank_i;
        end
    end

    assign restore_o = op_valid_i & (op_code_i == OP_RETURN_FAST ||
                                     op_code_i == OP_INT_EXIT_FAST);
    assign shadow_status_o = sh_status_r;
    assign shadow_working_o = sh_working_r;
    assign shadow_bank_o = sh_bank_r;

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_pc_even;
        pc_o[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc bit 0 not zero");

    property p_step;
        op_valid_i && op_code_i == OP_STEP |=> pc_o == pc_plus2($past(pc_o));
    endproperty
    a_step: assert property (p_step) else $error("step did not add two");

    property p_pcl_write;
        bus_wr && wb_adr_i == OFF_PC_LOW && !op_valid_i
        |=> pc_o[20:8] == $past({upper_latch_r, high_latch_r});
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("latches not loaded");

    property p_pcl_read;
        bus_rd && wb_adr_i == OFF_PC_LOW && !fault
        |=> high_latch_r == $past(pc_o[15:8]) && upper_latch_r == $past(pc_o[20:16]);
    endproperty
    a_pcl_read: assert property (p_pcl_read) else $error("latches not captured");

    property p_jump;
        op_valid_i && op_code_i == OP_JUMP
        |=> pc_o == word_align($past(op_target_i)) && $stable(high_latch_r);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_push;
        is_push && sp_r < SP_LAST_FREE
        |=> sp_r == $past(sp_inc) && tos == $past(pc_o);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");

    property p_pop;
        is_pop && op_code_i != OP_DISCARD && !pop_empty
        |=> pc_o == word_align($past(tos)) && sp_r == $past(sp_r) - 5'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop wrong");

    property p_saturate;
        !fault_enable_r && push_over |=> sp_r == SP_TOP && full_r;
    endproperty
    a_saturate: assert property (p_saturate) else $error("pointer left 31");

    property p_underflow;
        pop_empty && !fault_enable_r |=> pc_o == PC_RESET && underflow_r && sp_r == SP_EMPTY;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow wrong");

    property p_fault;
        fault |=> fault_reset_o && sp_r == SP_EMPTY && pc_o == PC_RESET ##1 !fault_reset_o;
    endproperty
    a_fault: assert property (p_fault) else $error("fault reset wrong");

    property p_full_kept;
        full_r && !(bus_wr && wb_adr_i == OFF_STACK_PTR) |=> full_r;
    endproperty
    a_full_kept: assert property (p_full_kept) else $error("full flag lost");

    property p_shadow;
        op_valid_i && op_code_i == OP_INT_ACK |=> shadow_status_o == $past(core_status_i)
        && shadow_bank_o == $past(core_bank_i);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not saved");

    c_call_return: cover property (is_push ##[1:20] is_pop);
    c_underflow: cover property (pop_empty);
    c_fault: cover property (fault_reset_o);
    c_pcl_write: cover property (bus_wr && wb_adr_i == OFF_PC_LOW);
endmodule

// >>> logic/prs_pkg.sv
// constants and command codes for the program counter and return stack block
package prs_pkg;
    // ******************************
    // widths and sizes
    // ******************************
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam int ADR_W = 8;

    // ******************************
    // register byte offsets
    // ******************************
    localparam logic [ADR_W-1:0] OFF_PC_LOW = 8'h00;
    localparam logic [ADR_W-1:0] OFF_HIGH_LATCH = 8'h04;
    localparam logic [ADR_W-1:0] OFF_UPPER_LATCH = 8'h08;
    localparam logic [ADR_W-1:0] OFF_STACK_PTR = 8'h0C;
    localparam logic [ADR_W-1:0] OFF_TOP_LOW = 8'h10;
    localparam logic [ADR_W-1:0] OFF_TOP_HIGH = 8'h14;
    localparam logic [ADR_W-1:0] OFF_TOP_UPPER = 8'h18;
    localparam logic [ADR_W-1:0] OFF_CONFIG = 8'h1C;
    localparam logic [ADR_W-1:0] OFF_PC_VIEW = 8'h20;

    // ******************************
    // field positions
    // ******************************
    localparam int SP_FULL_BIT = 7;
    localparam int SP_UNDERFLOW_BIT = 6;
    localparam int CFG_FAULT_RESET_BIT = 0;

    // ******************************
    // reset values and steps
    // ******************************
    localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
    localparam logic [SP_W-1:0] SP_LAST_FREE = 5'h1E;
    localparam logic [SP_W-1:0] SP_TOP = 5'h1F;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic FAULT_RESET_DEFAULT = 1'b1;

    // ******************************
    // core commands
    // ******************************
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_STEP = 4'h1,
        OP_JUMP = 4'h2,
        OP_CALL = 4'h3,
        OP_CALL_FAST = 4'h4,
        OP_RETURN = 4'h5,
        OP_RETURN_FAST = 4'h6,
        OP_INT_ACK = 4'h7,
        OP_INT_EXIT = 4'h8,
        OP_INT_EXIT_FAST = 4'h9,
        OP_PUSH = 4'hA,
        OP_DISCARD = 4'hB
    } prs_op_e;
endpackage

// >>> verification/prs_core_model.sv
// scripted core model that issues commands to the pc stack block
`timescale 1ns/1ps
module prs_core_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // results from the block
    input wire logic restore_i,
    input wire logic [7:0] sh_status_i,
    input wire logic [7:0] sh_working_i,
    input wire logic [7:0] sh_bank_i,
    // commands to the block
    output logic op_valid_o,
    output prs_pkg::prs_op_e op_code_o,
    output logic [prs_pkg::PC_W-1:0] op_target_o,
    output logic [7:0] status_o,
    output logic [7:0] working_o,
    output logic [7:0] bank_o
);
    import prs_pkg::*;
    logic [7:0] seq_r;

    initial begin
        op_valid_o = 1'b0;
        op_code_o = OP_NONE;
        op_target_o = '0;
        status_o = 8'h00;
        working_o = 8'h00;
        bank_o = 8'h00;
        seq_r = 8'h21;
    end

    // a fast exit hands the shadow copies back to the core registers
    always @(posedge clock_i) begin
        if (resetn_i && op_valid_o && restore_i) begin
            status_o <= sh_status_i;
            working_o <= sh_working_i;
            bank_o <= sh_bank_i;
        end
    end

    // one command per call; core registers change each time so copies can be told apart
    task automatic issue(input prs_op_e op, input logic [PC_W-1:0] tgt);
        @(posedge clock_i);
        op_valid_o <= 1'b1;
        op_code_o <= op;
        op_target_o <= tgt;
        status_o <= seq_r;
        working_o <= seq_r ^ 8'h5A;
        bank_o <= seq_r + 8'h03;
        seq_r <= seq_r + 8'h11;
        @(posedge clock_i);
        op_valid_o <= 1'b0;
        op_code_o <= OP_NONE;
        op_target_o <= ~tgt;
    endtask
endmodule

// >>> verification/test_prs_pc_stack.sv
// self-checking bench for the program counter and return stack block
`timescale 1ns/1ps
module test_prs_pc_stack;
    import prs_pkg::*;
    logic clock_i, resetn_i, wb_cyc, wb_stb, wb_we, wb_ack, op_valid, restore, fault;
    logic [7:0] wb_adr, st, wk, bk, sh_st, sh_wk, sh_bk;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    prs_op_e op_code;
    logic [PC_W-1:0] op_target, pc;
    int n_mismatch, n_compared, n_fault, n_restore;

    prs_pc_stack u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .op_valid_i(op_valid),
        .op_code_i(op_code), .op_target_i(op_target), .core_status_i(st),
        .core_working_i(wk), .core_bank_i(bk), .pc_o(pc), .restore_o(restore),
        .shadow_status_o(sh_st), .shadow_working_o(sh_wk), .shadow_bank_o(sh_bk),
        .fault_reset_o(fault));
    prs_core_model u_core (.clock_i(clock_i), .resetn_i(resetn_i), .restore_i(restore),
        .sh_status_i(sh_st), .sh_working_i(sh_wk), .sh_bank_i(sh_bk), .op_valid_o(op_valid),
        .op_code_o(op_code), .op_target_o(op_target), .status_o(st), .working_o(wk),
        .bank_o(bk));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // mid-cycle sampling keeps the counts clear of edge races
    always @(negedge clock_i) begin
        if (fault === 1'b1) n_fault++;
        if (op_valid === 1'b1 && restore === 1'b1) n_restore++;
    end

    // ******************************
    // shared tasks
    // ******************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'h1;
        wb_dat_w <= {24'h00_0000, d};
        // ack and read data are taken at the very edge that samples ack high
        do begin
            @(posedge clock_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(negedge clock_i);
        if (n == 50) n_mismatch++;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask
    task automatic rc(input logic [7:0] adr, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, adr, 8'h00, q);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic op(input prs_op_e o, input logic [PC_W-1:0] t);
        u_core.issue(o, t);
        // results of the command edge are settled by mid-cycle
        @(negedge clock_i);
    endtask
    task automatic pcc(input logic [PC_W-1:0] e);
        chk({11'h000, pc}, {11'h000, e});
    endtask
    task automatic wait_fault(input int f, input int e);
        repeat (2) @(posedge clock_i);
        chk(n_fault - f, e);
    endtask

    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset;
        pcc(21'h00_0000);
        rc(OFF_STACK_PTR, 8'h00);
        rc(OFF_CONFIG, 8'h01);
        rc(8'h40, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_pc;
        op(OP_STEP, '0);
        op(OP_STEP, '0);
        pcc(21'h00_0004);
        wr(OFF_HIGH_LATCH, 8'hAB);
        wr(OFF_UPPER_LATCH, 8'h1F);
        op(OP_JUMP, 21'h12_3455);
        pcc(21'h12_3454);
        wr(OFF_PC_LOW, 8'h57);
        pcc(21'h1F_AB56);
        op(OP_JUMP, 21'h0A_BCDE);
        rc(OFF_PC_LOW, 8'hDE);
        rc(OFF_HIGH_LATCH, 8'hBC);
        rc(OFF_UPPER_LATCH, 8'h0A);
        $display("test pc done");
    endtask
    task automatic t_call;
        wr(OFF_HIGH_LATCH, 8'h33);
        op(OP_CALL, 21'h00_2000);
        pcc(21'h00_2000);
        rc(OFF_STACK_PTR, 8'h01);
        rc(OFF_TOP_LOW, 8'hDE);
        rc(OFF_TOP_HIGH, 8'hBC);
        rc(OFF_TOP_UPPER, 8'h0A);
        op(OP_RETURN, '0);
        pcc(21'h0A_BCDE);
        rc(OFF_STACK_PTR, 8'h00);
        rc(OFF_HIGH_LATCH, 8'h33);
        op(OP_PUSH, '0);
        pcc(21'h0A_BCE0);
        wr(OFF_TOP_LOW, 8'h34);
        wr(OFF_TOP_HIGH, 8'h12);
        wr(OFF_TOP_UPPER, 8'h01);
        op(OP_RETURN, '0);
        pcc(21'h01_1234);
        op(OP_PUSH, '0);
        op(OP_PUSH, '0);
        op(OP_DISCARD, '0);
        rc(OFF_STACK_PTR, 8'h01);
        op(OP_DISCARD, '0);
        rc(OFF_STACK_PTR, 8'h00);
        wr(OFF_STACK_PTR, 8'h3F);
        rc(OFF_STACK_PTR, 8'h1F);
        wr(OFF_STACK_PTR, 8'hE5);
        rc(OFF_STACK_PTR, 8'h05);
        wr(OFF_STACK_PTR, 8'h00);
        $display("test call done");
    endtask
    // one empty pop with fault reset on, one with it off
    task automatic t_under(input logic [7:0] cfg, input int e);
        int f;
        f = n_fault;
        wr(OFF_CONFIG, cfg);
        op(OP_JUMP, 21'h00_0300);
        op(OP_RETURN, '0);
        wait_fault(f, e);
        pcc(21'h00_0000);
        rc(OFF_STACK_PTR, 8'h40);
        wr(OFF_STACK_PTR, 8'hC0);
        rc(OFF_STACK_PTR, 8'h40);
        wr(OFF_STACK_PTR, 8'h00);
        $display("test underflow done");
    endtask
    task automatic t_full;
        int f;
        op(OP_JUMP, 21'h00_1000);
        repeat (31) op(OP_PUSH, '0);
        rc(OFF_STACK_PTR, 8'h9F);
        op(OP_PUSH, '0);
        rc(OFF_STACK_PTR, 8'h9F);
        rc(OFF_TOP_LOW, 8'h3C);
        wr(OFF_STACK_PTR, 8'h00);
        wr(OFF_CONFIG, 8'h01);
        f = n_fault;
        op(OP_JUMP, 21'h00_1000);
        repeat (31) op(OP_PUSH, '0);
        wait_fault(f, 1);
        rc(OFF_STACK_PTR, 8'h80);
        pcc(21'h00_0000);
        wr(OFF_STACK_PTR, 8'h9F);
        rc(OFF_TOP_LOW, 8'h3E);
        wr(OFF_STACK_PTR, 8'h00);
        $display("test full done");
    endtask
    task automatic t_shadow;
        logic [23:0] s;
        int r;
        op(OP_INT_ACK, 21'h00_0008);
        op(OP_INT_ACK, 21'h00_0018);
        s = {st, wk, bk};
        chk({8'h00, sh_st, sh_wk, sh_bk}, {8'h00, s});
        r = n_restore;
        op(OP_INT_EXIT, '0);
        op(OP_CALL, 21'h00_0400);
        chk({8'h00, sh_st, sh_wk, sh_bk}, {8'h00, s});
        op(OP_RETURN, '0);
        chk(n_restore - r, 0);
        op(OP_CALL_FAST, 21'h00_0500);
        s = {st, wk, bk};
        chk({8'h00, sh_st, sh_wk, sh_bk}, {8'h00, s});
        op(OP_RETURN_FAST, '0);
        chk(n_restore - r, 1);
        pcc(21'h00_0008);
        op(OP_INT_EXIT_FAST, '0);
        chk(n_restore - r, 2);
        rc(OFF_STACK_PTR, 8'h00);
        $display("test shadow done");
    endtask

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole run needs a few hundred cycles; this leaves ample margin
    initial begin
        #(50 * 20000);
        n_mismatch++;
        end_sim;
    end

    initial begin
        resetn_i = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h1;
        wb_dat_w = 32'h0000_0000;
        n_mismatch = 0;
        n_compared = 0;
        n_fault = 0;
        n_restore = 0;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset;
        t_pc;
        t_call;
        t_under(8'h01, 1);
        t_under(8'h00, 0);
        t_full;
        t_shadow;
        end_sim;
    end
endmodule
